// ### ugs_phs_defines.vh
// Purpose: constants for the grant scheduler and suppression rule control
// Assumes: 125 MHz system clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
`ifndef UGS_PHS_DEFINES_VH
`define UGS_PHS_DEFINES_VH

// register byte offsets
`define A_CTRL      12'h000
`define A_INTERVAL  12'h004
`define A_JITTER    12'h008
`define A_GPI       12'h00c
`define A_TOS       12'h010
`define A_LATENCY   12'h014
`define A_TSTAMP    12'h018
`define A_REFTIME   12'h01c
`define A_STATUS    12'h020
`define A_CMD       12'h024
`define A_CMDARG    12'h028
`define A_RESP      12'h02c
`define A_RULECNT   12'h030
`define A_SUPSIZE   12'h034
// control fields
`define CTRL_EN     0
`define CTRL_ACT    1
`define CTRL_TOSEN  2
`define CTRL_EXCESS 3
// suppression actions
`define ACT_ADD     2'h0
`define ACT_SET     2'h1
`define ACT_DEL     2'h2
`define ACT_DELALL  2'h3
// confirmation codes
`define CC_OK       8'h00
`define CC_OTHER    8'h01
`define CC_UNRECOG  8'h02
`define CC_RESOURCE 8'h03
// errored parameter subtypes
`define SUB_INDEX   8'h08
`define SUB_ACTION  8'h05
`define SUB_FLOW    8'h04
`define SUB_SIZE    8'h0a
// limits
`define GPI_MAX     7'h7f
`define TLV_MAX_LEN 8'hff
// timing: system clock period in ns, master tick 10,24 MHz as 1024/100 MHz
`define CLK_NS      8
`define TICK_NUM    32'd1024
`define TICK_DEN    32'd12500
`define US_CYCLES   125
`endif

// ### ugs_grant_and_phs_rule_control.v
// Purpose: unsolicited grant scheduler, tos rewrite, latency watch, suppression rules
// Assumes: APB slave, inputs synchronous to CLK_SYS
// Notes: rule table indexed by suppression index low bits
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ugs_phs_defines.vh"

module ugs_grant_and_phs_rule_control #(
  parameter RULES = 8,
  parameter RIDX_W = 3
) (
  input wire CLK_SYS,              // system clock 125 MHz
  input wire RST_N,                // async reset, active low
  input wire PSEL,                 // apb select
  input wire PENABLE,              // apb enable
  input wire PWRITE,               // apb direction
  input wire [11:0] PADDR,         // apb byte address
  input wire [31:0] PWDATA,        // apb write data
  output wire PREADY,              // apb ready
  output reg [31:0] PRDATA,        // apb read data
  output wire PSLVERR,             // apb error
  input wire [7:0] TOS_IN,         // tos byte of matching packet
  input wire TOS_VALID,            // packet tos valid
  output reg [7:0] TOS_OUT,        // rewritten tos byte
  output reg TOS_OUT_VALID,        // rewritten tos valid
  input wire PKT_ARRIVE,           // packet taken on network side port
  input wire PKT_FORWARD,          // oldest packet sent to cable port
  output reg GRANT_PULSE,          // unsolicited grant opportunity
  output reg [31:0] REF_TIME,      // time reference for the modem
  output reg REF_SEND,             // send reference, one pulse
  output reg LATENCY_FAULT         // latency exceeded, sticky
);

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire wr = PSEL & PENABLE & PWRITE;
  wire rd_en = PSEL & ~PENABLE & ~PWRITE;
  wire known = (PADDR[11:6] == 6'h00) && (PADDR[5:2] <= 4'hd) && (PADDR[1:0] == 2'h0);
  assign PREADY = 1'b1;  // zero wait states keeps the slave trivial
  assign PSLVERR = PSEL & PENABLE & ~known;

  reg [3:0] ctrl_q;
  reg [31:0] interval_q, jitter_q, latency_q;
  reg [6:0] gpi_q;
  reg [15:0] tos_q;
  reg [31:0] tstamp_q;
  reg [31:0] frac_q;

  ////////////////////////////////////////////////////////////////////////
  // master timestamp: 10,24 MHz ticks derived by fractional accumulator
  wire [31:0] frac_sum = frac_q + `TICK_NUM;
  wire tick = (frac_sum >= `TICK_DEN);
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      frac_q <= 32'h0;
      tstamp_q <= 32'h0;
    end else begin
      frac_q <= tick ? frac_sum - `TICK_DEN : frac_sum;
      if (tick) begin
        tstamp_q <= tstamp_q + 32'h1;  // wraps at 2^32
      end
    end
  end

  // microsecond strobe for interval and jitter counting
  reg [6:0] us_q;
  wire us_tick = (us_q == 7'd`US_CYCLES - 7'd1);
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      us_q <= 7'h0;
    end else begin
      us_q <= us_tick ? 7'h0 : us_q + 7'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // grant scheduler: at each interval start, issue gpi grants back to back
  reg [31:0] ivl_cnt_q;
  reg [6:0] left_q;
  reg [31:0] since_q;
  reg act_q;
  wire run = ctrl_q[`CTRL_EN] & (interval_q != 32'h0);
  wire ivl_start = run & us_tick & (ivl_cnt_q == 32'h0);
  // stop issuing past jitter or interval end, whichever first
  wire in_window = (since_q <= jitter_q) & (since_q < interval_q);
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ivl_cnt_q <= 32'h0;
      left_q <= 7'h0;
      since_q <= 32'h0;
      GRANT_PULSE <= 1'b0;
      act_q <= 1'b0;
      REF_SEND <= 1'b0;
      REF_TIME <= 32'h0;
    end else begin
      act_q <= ctrl_q[`CTRL_EN];
      REF_SEND <= 1'b0;
      if (ctrl_q[`CTRL_EN] & ~act_q) begin
        REF_TIME <= tstamp_q;  // ideal time of first grant
        REF_SEND <= 1'b1;
      end
      GRANT_PULSE <= 1'b0;
      if (!run) begin
        ivl_cnt_q <= 32'h0;
        left_q <= 7'h0;
        since_q <= 32'h0;
      end else begin
        if (us_tick) begin
          ivl_cnt_q <= (ivl_cnt_q == interval_q - 32'h1) ? 32'h0 : ivl_cnt_q + 32'h1;
          since_q <= ivl_start ? 32'h0 : since_q + 32'h1;
        end
        if (ivl_start) begin
          left_q <= gpi_q;  // at most gpi_q grants per interval
        end else if (left_q != 7'h0 && in_window) begin
          GRANT_PULSE <= 1'b1;
          left_q <= left_q - 7'h1;
        end else if (!in_window) begin
          left_q <= 7'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tos overwrite
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TOS_OUT <= 8'h0;
      TOS_OUT_VALID <= 1'b0;
    end else begin
      TOS_OUT_VALID <= TOS_VALID;
      if (ctrl_q[`CTRL_TOSEN]) begin
        TOS_OUT <= (TOS_IN & tos_q[15:8]) | tos_q[7:0];
      end else begin
        TOS_OUT <= TOS_IN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latency watch on oldest packet, one outstanding at a time
  reg [31:0] age_q;
  reg busy_q;
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      age_q <= 32'h0;
      busy_q <= 1'b0;
      LATENCY_FAULT <= 1'b0;
    end else begin
      if (PKT_FORWARD) begin
        busy_q <= PKT_ARRIVE;
        age_q <= 32'h0;
      end else if (PKT_ARRIVE & ~busy_q) begin
        busy_q <= 1'b1;
        age_q <= 32'h0;
      end else if (busy_q & us_tick) begin
        age_q <= age_q + 32'h1;
      end
      // waived for flows above reserved rate
      if (busy_q && latency_q != 32'h0 && age_q > latency_q && !ctrl_q[`CTRL_EXCESS]) begin
        LATENCY_FAULT <= 1'b1;
      end else if (wr && PADDR == `A_STATUS && PWDATA[0]) begin
        LATENCY_FAULT <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // suppression rule table
  reg [RULES-1:0] used_q, hasf_q, hass_q;
  reg [31:0] flow_q [0:RULES-1];
  reg [7:0] size_q [0:RULES-1];
  reg [31:0] resp_q;
  reg [31:0] arg_q;
  wire [7:0] c_index = PWDATA[7:0];
  wire [1:0] c_act = PWDATA[9:8];
  wire c_field = PWDATA[10];
  wire c_size = PWDATA[11];
  wire [7:0] c_size_v = PWDATA[23:16];
  wire [7:0] c_len = PWDATA[31:24];
  wire [RIDX_W-1:0] slot = c_index[RIDX_W-1:0];
  wire do_cmd = wr && PADDR == `A_CMD;
  reg [7:0] rc_q;
  integer i;
  // response: cc in [7:0], errored subtype in [15:8], error flag bit 16
  // word replaced whole per command and kept apart from the command word
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      used_q <= {RULES{1'b0}};
      hasf_q <= {RULES{1'b0}};
      hass_q <= {RULES{1'b0}};
      resp_q <= 32'h0;
      for (i = 0; i < RULES; i = i + 1) begin
        flow_q[i] <= 32'h0;
        size_q[i] <= 8'h0;
      end
    end else if (do_cmd) begin
      if (arg_q == 32'h0) begin
        resp_q <= {15'h0, 1'b1, `SUB_FLOW, `CC_OTHER};
      end else if (c_len >= `TLV_MAX_LEN) begin
        resp_q <= {15'h0, 1'b1, 8'h00, `CC_UNRECOG};
      end else if (c_act != `ACT_DELALL && (c_index == 8'h0 || c_index[7:RIDX_W] != {(8-RIDX_W){1'b0}})) begin
        resp_q <= {15'h0, 1'b1, `SUB_INDEX, `CC_RESOURCE};  // reference zero refused
      end else begin
        case (c_act)
          `ACT_ADD: begin
            if (used_q[slot]) begin
              resp_q <= {15'h0, 1'b1, `SUB_INDEX, `CC_OTHER};
            end else begin
              used_q[slot] <= 1'b1;
              flow_q[slot] <= arg_q;
              hasf_q[slot] <= c_field;
              hass_q[slot] <= c_size;
              size_q[slot] <= c_size ? c_size_v : 8'h0;
              resp_q <= 32'h0;  // no error encoding on success
            end
          end
          `ACT_SET: begin
            if (!used_q[slot] || (hasf_q[slot] & hass_q[slot]) ||
                (c_field & hasf_q[slot]) || (c_size & hass_q[slot])) begin
              resp_q <= {15'h0, 1'b1, `SUB_ACTION, `CC_OTHER};
            end else begin
              hasf_q[slot] <= hasf_q[slot] | c_field;
              hass_q[slot] <= hass_q[slot] | c_size;
              if (c_size) begin
                size_q[slot] <= c_size_v;
              end
              resp_q <= 32'h0;
            end
          end
          `ACT_DEL: begin
            if (!used_q[slot]) begin
              resp_q <= {15'h0, 1'b1, `SUB_INDEX, `CC_OTHER};
            end else begin
              used_q[slot] <= 1'b0;
              hasf_q[slot] <= 1'b0;
              hass_q[slot] <= 1'b0;
              resp_q <= 32'h0;
            end
          end
          default: begin
            for (i = 0; i < RULES; i = i + 1) begin
              if (flow_q[i] == arg_q) begin
                used_q[i] <= 1'b0;
                hasf_q[i] <= 1'b0;
                hass_q[i] <= 1'b0;
              end
            end
            resp_q <= 32'h0;
          end
        endcase
      end
    end
  end

  // count of rules actively suppressing: fully defined and nonzero size
  reg [7:0] active_cnt;
  integer j;
  always @* begin
    active_cnt = 8'h0;
    for (j = 0; j < RULES; j = j + 1) begin
      if (used_q[j] & hasf_q[j] & hass_q[j] & (size_q[j] != 8'h0)) begin
        active_cnt = active_cnt + 8'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 4'h0;
      interval_q <= 32'h0;
      jitter_q <= 32'h0;
      gpi_q <= 7'h0;
      tos_q <= 16'hff00;
      latency_q <= 32'h0;
      arg_q <= 32'h0;
    end else if (wr) begin
      if (PADDR == `A_CTRL) begin
        ctrl_q <= PWDATA[3:0];
      end else if (PADDR == `A_INTERVAL) begin
        interval_q <= PWDATA;
      end else if (PADDR == `A_JITTER) begin
        jitter_q <= PWDATA;
      end else if (PADDR == `A_GPI) begin
        gpi_q <= PWDATA[6:0];  // top bit dropped keeps range 0..127
      end else if (PADDR == `A_TOS) begin
        tos_q <= PWDATA[15:0];
      end else if (PADDR == `A_LATENCY) begin
        latency_q <= PWDATA;
      end else if (PADDR == `A_CMDARG) begin
        arg_q <= PWDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered in the setup phase
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
    end else if (rd_en) begin
      if (PADDR == `A_CTRL) begin
        PRDATA <= {28'h0, ctrl_q};
      end else if (PADDR == `A_INTERVAL) begin
        PRDATA <= interval_q;
      end else if (PADDR == `A_JITTER) begin
        PRDATA <= jitter_q;
      end else if (PADDR == `A_GPI) begin
        PRDATA <= {25'h0, gpi_q};
      end else if (PADDR == `A_TOS) begin
        PRDATA <= {16'h0, tos_q};
      end else if (PADDR == `A_LATENCY) begin
        PRDATA <= latency_q;
      end else if (PADDR == `A_TSTAMP) begin
        PRDATA <= tstamp_q;
      end else if (PADDR == `A_REFTIME) begin
        PRDATA <= REF_TIME;
      end else if (PADDR == `A_STATUS) begin
        PRDATA <= {24'h0, left_q != 7'h0, busy_q, act_q, 4'h0, LATENCY_FAULT};
      end else if (PADDR == `A_CMDARG) begin
        PRDATA <= arg_q;
      end else if (PADDR == `A_RESP) begin
        PRDATA <= resp_q;
      end else if (PADDR == `A_RULECNT) begin
        PRDATA <= {{(32-RULES){1'b0}}, used_q};
      end else if (PADDR == `A_SUPSIZE) begin
        PRDATA <= {24'h0, active_cnt};
      end else begin
        PRDATA <= 32'h0;
      end
    end
  end

endmodule
`default_nettype wire

// ### ugs_phs_monitor.sv
// Purpose: port checker for the grant scheduler and rule control block
// Assumes: sees top ports only, shadows control words from apb writes
// Notes: shadows cover ctrl, gpi, tos and latency words
`timescale 1ns/10ps
`default_nettype none
`include "ugs_phs_defines.vh"
module ugs_phs_monitor (
  input wire logic CLK_SYS, // clock
  input wire logic RST_N, // reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic PREADY, // apb ready
  input wire logic [31:0] PRDATA, // apb read data
  input wire logic PSLVERR, // apb error
  input wire logic [7:0] TOS_IN, // tos in
  input wire logic TOS_VALID, // tos in valid
  input wire logic [7:0] TOS_OUT, // tos out
  input wire logic TOS_OUT_VALID, // tos out valid
  input wire logic PKT_ARRIVE, // packet in
  input wire logic PKT_FORWARD, // packet out
  input wire logic GRANT_PULSE, // grant
  input wire logic [31:0] REF_TIME, // reference time
  input wire logic REF_SEND, // reference pulse
  input wire logic LATENCY_FAULT // latency fault
);
  logic [31:0] ctrl_q, gpi_q, tos_q, lat_q;
  logic [7:0] run_q;
  logic wr;
  assign wr = PSEL && PENABLE && PWRITE;
  ////////////////////////////////////////////////////////////////
  // shadows land on the same edge as the block's own registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 32'h0;
      gpi_q <= 32'h0;
      tos_q <= 32'hff00;
      lat_q <= 32'h0;
      run_q <= 8'h0;
    end else begin
      if (wr && PADDR == `A_CTRL) ctrl_q <= PWDATA;
      if (wr && PADDR == `A_GPI) gpi_q <= {25'h0, PWDATA[6:0]};
      if (wr && PADDR == `A_TOS) tos_q <= PWDATA;
      if (wr && PADDR == `A_LATENCY) lat_q <= PWDATA;
      run_q <= GRANT_PULSE ? run_q + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_tos_rewrite:
    assert property (TOS_VALID |=> TOS_OUT_VALID && TOS_OUT == ($past(ctrl_q[2]) ?
      (($past(TOS_IN) & $past(tos_q[15:8])) | $past(tos_q[7:0])) : $past(TOS_IN)))
    else $error("tos byte mismatch");
  a_ref_delay:
    assert property ($rose(ctrl_q[0]) |-> ##[0:3] REF_SEND) else $error("no reference sent");
  a_ref_single:
    assert property (REF_SEND |=> !REF_SEND) else $error("reference pulse too long");
  a_ref_cause:
    assert property ($rose(REF_SEND) |-> ctrl_q[0]) else $error("reference without flow");
  a_grant_count:
    assert property (GRANT_PULSE |-> run_q < gpi_q[7:0]) else $error("too many grants");
  a_grant_idle:
    assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !GRANT_PULSE) else $error("grant while off");
  a_fault_clear:
    assert property ($fell(LATENCY_FAULT) |-> $past(wr && PADDR == `A_STATUS && PWDATA[0]))
    else $error("fault dropped by itself");
  a_fault_waiver:
    assert property ($rose(LATENCY_FAULT) |-> !$past(ctrl_q[3]) && $past(lat_q) != 32'h0)
    else $error("fault while waived");
  a_slverr_map:
    assert property (PSEL && PENABLE |-> PREADY && PSLVERR == (PADDR > `A_SUPSIZE || PADDR[1:0] != 2'h0))
    else $error("apb answer wrong");
endmodule
bind ugs_grant_and_phs_rule_control ugs_phs_monitor mon_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .TOS_IN(TOS_IN), .TOS_VALID(TOS_VALID), .TOS_OUT(TOS_OUT),
  .TOS_OUT_VALID(TOS_OUT_VALID), .PKT_ARRIVE(PKT_ARRIVE), .PKT_FORWARD(PKT_FORWARD),
  .GRANT_PULSE(GRANT_PULSE), .REF_TIME(REF_TIME), .REF_SEND(REF_SEND), .LATENCY_FAULT(LATENCY_FAULT));
`default_nettype wire

// ### ugs_modem_model.sv
// Purpose: behavioural subscriber modem on the far side of the grants
// Assumes: own 10,24 mhz count started at the same reset as the head end
// Notes: no ranging or sync, but the same fractional step from the same reset keeps its count equal to the head end count
`timescale 1ns/10ps
`default_nettype none
module ugs_modem_model (
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset, active low
  input wire logic grant_pulse, // grant seen
  input wire logic [31:0] ref_time, // reference time
  input wire logic ref_send, // reference pulse
  input wire logic [31:0] interval_us, // nominal interval
  output logic [31:0] grant_cnt, // grants counted
  output logic [31:0] off_us // time to next ideal grant
);
  logic [31:0] now_q, frac_q;
  function automatic logic [31:0] next_off(input logic [31:0] r, input logic [31:0] n, input logic [31:0] iv);
    logic [63:0] d;
    if ($signed(r - n) > 0) begin
      d = {32'h0, r - n} * 64'd100 / 64'd1024;
      return d[31:0];
    end
    d = {32'h0, n - r} * 64'd100 / 64'd1024;
    return iv - d[31:0] % iv;
  endfunction
  ////////////////////////////////////////////////////////////////
  // fractional step keeps the average rate without a second clock
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      now_q <= 32'h0;
      frac_q <= 32'h0;
      grant_cnt <= 32'h0;
      off_us <= 32'h0;
    end else begin
      frac_q <= (frac_q + 32'd1024) % 32'd12500;
      if (frac_q + 32'd1024 >= 32'd12500) now_q <= now_q + 32'h1;
      if (grant_pulse) grant_cnt <= grant_cnt + 32'h1;
      if (ref_send) off_us <= next_off(ref_time, now_q, interval_us);
    end
  end
endmodule
`default_nettype wire

// ### ugs_grant_and_phs_rule_control_tb.sv
// Purpose: self-checking bench for grants, tos rewrite, latency and rules
// Assumes: apb answers in one or more access cycles, handled by waiting on ready
// Notes: random tos bytes, masks and jitter from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "ugs_phs_defines.vh"
module ugs_grant_and_phs_rule_control_tb;
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic tos_valid = 0, pkt_arrive = 0, pkt_forward = 0, err_q, seen;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, m, cnt;
  logic [7:0] tos_in = 0, b;
  wire logic pready, pslverr, tos_out_valid, grant_pulse, ref_send, latency_fault;
  wire logic [31:0] prdata, ref_time, grant_cnt, off_us;
  wire logic [7:0] tos_out;
  int num_errors = 0, n_tests = 0, cyc = 0;
  logic [31:0] tbl [13][4] = '{'{5, 32'h0a040c01, 0, 0}, '{5, 32'h0a040c01, 8, 1},
    '{5, 32'h0a040d01, 5, 1}, '{5, 32'h0a000c02, 0, 0}, '{0, 32'h0a040c03, 4, 1},
    '{5, 32'hff040c03, 0, 2}, '{5, 32'h0a040c00, 8, 3}, '{5, 32'h0a040404, 0, 0},
    '{5, 32'h0a040904, 0, 0}, '{5, 32'h0a000202, 0, 0}, '{5, 32'h0a000202, 8, 1},
    '{6, 32'h0a040c03, 0, 0}, '{5, 32'h0a000301, 0, 0}};
  logic [6:0] gl [3] = '{7'h0, 7'h3, 7'h7f};
  ugs_grant_and_phs_rule_control dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .TOS_IN(tos_in), .TOS_VALID(tos_valid), .TOS_OUT(tos_out),
    .TOS_OUT_VALID(tos_out_valid), .PKT_ARRIVE(pkt_arrive), .PKT_FORWARD(pkt_forward),
    .GRANT_PULSE(grant_pulse), .REF_TIME(ref_time), .REF_SEND(ref_send), .LATENCY_FAULT(latency_fault));
  ugs_modem_model modem_u (.clk_sys(clk_sys), .rst_n(rst_n), .grant_pulse(grant_pulse),
    .ref_time(ref_time), .ref_send(ref_send), .interval_us(32'd10), .grant_cnt(grant_cnt), .off_us(off_us));
  ////////////////////////////////////////////////////////////////
  // 125 mhz clock and a cycle ceiling well above the planned run
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, request held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] tos_exp(input logic en, input logic [7:0] v, input logic [15:0] k);
    return en ? (v & k[15:8]) | k[7:0] : v;
  endfunction
  function automatic logic [31:0] resp_exp(input logic [7:0] sub, input logic [7:0] cc);
    return (cc == 8'h0) ? 32'h0 : {15'h0, 1'b1, sub, cc};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8916));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, `A_TOS, 0);
    chk(rd, 32'hff00);
    apb(1'b0, 12'h03c, 0);
    chk({rd[30:0], err_q}, 32'h1);
    // tos pass-through, then rewrite with random masks
    for (int k = 0; k < 2; k++) begin
      m = {16'h0, 16'($urandom)};
      apb(1'b1, `A_TOS, m);
      apb(1'b1, `A_CTRL, k << 2);
      repeat (20) begin
        @(posedge clk_sys);
        b = 8'($urandom);
        tos_in <= b;
        tos_valid <= 1'b1;
        @(posedge clk_sys);
        tos_valid <= 1'b0;
        @(negedge clk_sys);
        chk({23'h0, tos_out_valid, tos_out}, {23'h1, tos_exp(k[0], b, m[15:0])});
      end
    end
    // grants: none, a few, and the top of the count range
    apb(1'b1, `A_INTERVAL, 32'd10);
    apb(1'b1, `A_JITTER, $urandom_range(9, 2));
    foreach (gl[i]) begin
      apb(1'b1, `A_CTRL, 0);
      apb(1'b1, `A_GPI, {24'h0, 1'b1, gl[i]});
      apb(1'b0, `A_GPI, 0);
      chk(rd, {25'h0, gl[i]});
      apb(1'b1, `A_CTRL, 1);
      seen = 1'b0;
      repeat (6) begin
        @(negedge clk_sys);
        seen = seen | ref_send;
      end
      chk({31'h0, seen}, 32'h1);
      chk({31'h0, off_us <= 32'd10}, 32'h1);
      // reference must be the timestamp of a few cycles ago
      apb(1'b0, `A_TSTAMP, 0);
      chk({31'h0, rd - ref_time < 32'd4}, 32'h1);
      cnt = grant_cnt;
      repeat (6250) @(posedge clk_sys);
      cnt = grant_cnt - cnt;
      chk({31'h0, cnt >= 4 * gl[i] && cnt <= 6 * gl[i]}, 32'h1);
    end
    // latency watch, then the same with the over-rate waiver
    apb(1'b1, `A_LATENCY, 32'd2);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `A_CTRL, k << 3);
      @(posedge clk_sys);
      pkt_arrive <= 1'b1;
      @(posedge clk_sys);
      pkt_arrive <= 1'b0;
      repeat (125) @(negedge clk_sys);
      chk({31'h0, latency_fault}, 32'h0);
      repeat (375) @(negedge clk_sys);
      chk({31'h0, latency_fault}, {31'h0, ~k[0]});
      apb(1'b0, `A_STATUS, 0);
      chk(rd, {24'h0, 7'h20, ~k[0]});
      @(posedge clk_sys);
      pkt_forward <= 1'b1;
      @(posedge clk_sys);
      pkt_forward <= 1'b0;
      apb(1'b1, `A_STATUS, 1);
      @(negedge clk_sys);
      chk({31'h0, latency_fault}, 32'h0);
    end
    // suppression commands, answers read back from the response word
    foreach (tbl[i]) begin
      apb(1'b1, `A_CMDARG, tbl[i][0]);
      apb(1'b1, `A_CMD, tbl[i][1]);
      apb(1'b0, `A_RESP, 0);
      m = (tbl[i][3] == 2) ? 32'h100ff : 32'hffffffff;
      chk(rd & m, resp_exp(tbl[i][2][7:0], tbl[i][3][7:0]) & m);
      if (i == 3) begin
        apb(1'b0, `A_SUPSIZE, 0);
        chk(rd, 32'h1);
      end
    end
    apb(1'b0, `A_RULECNT, 0);
    chk(rd, 32'h8);
    complete_run();
  end
endmodule
`default_nettype wire
